// ==== core/addr_bus_map.svh ====
// Constants of the address bus request and tenure logic.
// Assumes both ends share one processor clock and one synchronous reset.
`ifndef ADDR_BUS_MAP_SVH
`define ADDR_BUS_MAP_SVH

// Processor clock period and bus clock ratio in processor clocks
`define ABM_PCLK_PERIOD_NS 4
`define ABM_BUS_RATIO 2

// Widths
`define ABM_ADDR_W 64
`define ABM_ATTR_W 10
`define ABM_PAR_W 3
`define ABM_DIV_W 8

// Parity bit positions: high address word, low address word, attributes
`define ABM_AP_HIGH_WORD 0
`define ABM_AP_LOW_WORD 1
`define ABM_AP_ATTR 2

// Reset level of every active-low bus line and of an idle bus
`define ABM_NEGATED 1'b1
`define ABM_IDLE_ADDR 64'hFFFF_FFFF_FFFF_FFFF
`define ABM_IDLE_ATTR 10'h3FF
`define ABM_IDLE_PAR 3'h7

`endif

// ==== core/addr_bus_pkg.sv ====
// Types shared by the master end, the arbiter end and the bus interface.
// Assumes addr_bus_map.svh is on the include path.
`include "addr_bus_map.svh"

package addr_bus_pkg;

	typedef logic [`ABM_ADDR_W-1:0] addr_t;
	typedef logic [`ABM_PAR_W-1:0] parity_t;

	typedef struct packed {
		logic [4:0] kind;
		logic [3:0] sizeData;
		logic sizeBurst;
	} attr_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'h1,
		M_REQ = 3'h2,
		M_DRIVE = 3'h4
	} master_state_t;

	typedef enum logic [2:0] {
		A_IDLE = 3'h1,
		A_GRANT = 3'h2,
		A_START = 3'h4
	} arb_state_t;

endpackage : addr_bus_pkg

// ==== core/addr_bus_if.sv ====
// Address arbitration and address transfer lines between one master and the arbiter.
// Assumes the arbiter end also models one other bus master; idle lines float high.
`timescale 1ns/1ps
`include "addr_bus_map.svh"

interface addr_bus_if;
	import addr_bus_pkg::*;

	logic addrBusRequestN;
	logic addrBusGrantN;
	logic highPriorityRequestN;
	logic dataBusRequestN;
	logic earlyAddrStartN;
	addr_t devAddr;
	attr_t devAttr;
	parity_t devParity;
	logic devAddrOe;
	addr_t othAddr;
	logic othAddrOe;
	addr_t addrBus;
	attr_t attrBus;
	parity_t addrParity;

	// Pull-ups resolve an undriven bus
	assign addrBus = devAddrOe ? devAddr : (othAddrOe ? othAddr : `ABM_IDLE_ADDR);
	assign attrBus = devAddrOe ? devAttr : `ABM_IDLE_ATTR;
	assign addrParity = devAddrOe ? devParity : `ABM_IDLE_PAR;

	modport dev_end (
		output addrBusRequestN, highPriorityRequestN, dataBusRequestN,
		output devAddr, devAttr, devParity, devAddrOe,
		input addrBusGrantN, earlyAddrStartN, addrBus, attrBus, addrParity
	);

	modport arb_end (
		input addrBusRequestN, highPriorityRequestN, dataBusRequestN,
		input addrBus, attrBus, addrParity,
		output addrBusGrantN, earlyAddrStartN, othAddr, othAddrOe
	);

endinterface : addr_bus_if

// ==== core/bus_clk_div.sv ====
// Bus clock enable divider: one-cycle pulses on the processor clock.
// Assumes RATIO of at least 1; both ends reset together and stay aligned.
`timescale 1ns/1ps
`include "addr_bus_map.svh"

module bus_clk_div #(
	parameter int RATIO = `ABM_BUS_RATIO
) (
	input wire logic clk_sys, // Processor clock
	input wire logic srst, // Synchronous reset, active high
	output logic busTick, // Last processor clock of a bus cycle
	output logic busPreTick // Processor clock before busTick
);
	logic [`ABM_DIV_W-1:0] cnt_q;
	wire logic [`ABM_DIV_W-1:0] lastCnt = `ABM_DIV_W'(RATIO - 1);
	wire logic [`ABM_DIV_W-1:0] preCnt = (RATIO < 2) ? lastCnt : `ABM_DIV_W'(RATIO - 2);

	assign busTick = (cnt_q == lastCnt);
	assign busPreTick = (cnt_q == preCnt);

	always_ff @(posedge clk_sys) begin
		if (srst || busTick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + `ABM_DIV_W'(1);
		end
	end
endmodule : bus_clk_div

// ==== core/addr_bus_master.sv ====
// Master end: address bus request, high-priority request, address tenure and snoop capture.
// Assumes the arbiter end runs on the same processor clock and reset.
//
// Functional notes
// - Request bus when transaction waits, no grant
// - Level request, one outstanding at most
// - Drop request once grant is received
// - Grant is one bus cycle low pulse
// - Drive address at grant edge or later
// - Arbiter grants only while request asserted
// - Grants at least every other bus cycle
// - Negated grant means bus not ours
// - High priority when request and high op
// - Earlier low operation inherits high priority
// - Hold high priority until none queued
// - Drivers off one cycle after start sampled
// - Snoopers sample address one cycle after start
// - Start same or next cycle after grant
// - Same-cycle start gives one-cycle tenure
// - Late start: two bus clocks, lookahead shortens
// - Start negates one bus cycle later
// - Drive address from cycle after grant
// - Release bus after start is negated
// - Address from other master is snooped
// - Start line shared or point-to-point
// - Three odd parity bits with address
`timescale 1ns/1ps
`include "addr_bus_map.svh"

module addr_bus_master #(
	parameter int BUS_RATIO = `ABM_BUS_RATIO
) (
	input wire logic clk_sys, // Processor clock, 250 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic busLookaheadEnable, // Shortens a late-start tenure
	input wire logic txnValid, // Transaction waiting for the bus
	input wire addr_bus_pkg::addr_t txnAddr, // Physical address of it
	input wire addr_bus_pkg::attr_t txnAttr, // Type and size of it
	input wire logic txnHighPri, // Transaction is high priority
	input wire logic queuedHighPri, // High-priority op queued behind it
	input wire logic dataReq, // Data bus wanted
	input wire logic dataHighPri, // Data bus op is high priority
	output logic txnReady, // Takes txnValid at the next bus edge
	output logic tenureDone, // Pulse: own address tenure ended
	output logic snoopValid, // Pulse: snoopAddr holds a new address
	output addr_bus_pkg::addr_t snoopAddr, // Snooped physical address
	addr_bus_if.dev_end bus // Bus lines
);
	import addr_bus_pkg::*;

	logic busTick;
	logic busPreTick;
	master_state_t state_q;
	master_state_t state_d;
	addr_t addr_q;
	attr_t attr_q;
	parity_t parity_q;
	logic reqN_q;
	logic hprN_q;
	logic dbrN_q;
	logic oe_q;
	logic high_q;
	logic armed_q;
	logic late_q;
	logic snoopArm_q;
	logic snoopValid_q;
	addr_t snoopAddr_q;
	logic done_q;
	logic ready_q;

	bus_clk_div #(.RATIO(BUS_RATIO)) bus_clk_div_inst (
		.clk_sys(clk_sys),
		.srst(srst),
		.busTick(busTick),
		.busPreTick(busPreTick)
	);

	// Decode of bus events, sampled on bus edges except the lookahead release on busPreTick
	wire logic eatsLow = !bus.earlyAddrStartN;
	wire logic isIdle = (state_q == M_IDLE);
	wire logic isReq = (state_q == M_REQ);
	wire logic isDrive = (state_q == M_DRIVE);
	wire logic accept = busTick && isIdle && txnValid;
	wire logic grantSeen = busTick && isReq && !bus.addrBusGrantN;
	wire logic armNow = busTick && isDrive && !armed_q;
	wire logic relEdge = (busLookaheadEnable && late_q) ? busPreTick : busTick;
	wire logic relNow = isDrive && armed_q && relEdge;
	wire logic snoopStart = busTick && eatsLow && !isDrive && !grantSeen;
	wire logic reqActive = !reqN_q || dataReq;
	wire logic highNeed = high_q || queuedHighPri || dataHighPri;

	// Odd parity: the bit makes the count of ones odd
	function automatic parity_t oddParity(input addr_t a, input attr_t t);
		parity_t p;
		p = '0;
		p[`ABM_AP_HIGH_WORD] = ~^a[63:32];
		p[`ABM_AP_LOW_WORD] = ~^a[31:0];
		p[`ABM_AP_ATTR] = ~^t;
		return p;
	endfunction : oddParity

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			M_IDLE: begin
				if (accept) begin
					state_d = M_REQ;
				end
			end
			M_REQ: begin
				if (grantSeen) begin
					state_d = M_DRIVE;
				end
			end
			M_DRIVE: begin
				if (relNow) begin
					state_d = M_IDLE;
				end
			end
			default: begin
				state_d = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= M_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Request line, one transaction held at a time
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reqN_q <= `ABM_NEGATED;
			ready_q <= 1'b0;
		end else begin
			if (accept) begin
				reqN_q <= 1'b0;
			end else if (grantSeen) begin
				reqN_q <= `ABM_NEGATED;
			end
			ready_q <= isIdle ? !accept : (relNow && !busTick);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (accept) begin
			addr_q <= txnAddr;
			attr_q <= txnAttr;
			parity_q <= oddParity(txnAddr, txnAttr);
		end
	end

	// Priority tracking, raised by queuedHighPri on any clock in M_REQ, and the two request lines updated on bus edges
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			high_q <= 1'b0;
			hprN_q <= `ABM_NEGATED;
			dbrN_q <= `ABM_NEGATED;
		end else begin
			if (accept) begin
				high_q <= txnHighPri;
			end else if (grantSeen) begin
				high_q <= 1'b0;
			end else if (isReq && queuedHighPri) begin
				high_q <= 1'b1;
			end
			if (busTick) begin
				hprN_q <= !(reqActive && highNeed);
				dbrN_q <= !dataReq;
			end
		end
	end

	// Address tenure: drive from the grant edge, release after start
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			oe_q <= 1'b0;
			armed_q <= 1'b0;
			late_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= relNow;
			if (grantSeen) begin
				oe_q <= 1'b1;
				armed_q <= eatsLow;
				late_q <= 1'b0;
			end else if (armNow) begin
				armed_q <= 1'b1;
				late_q <= 1'b1;
			end else if (relNow) begin
				oe_q <= 1'b0;
				armed_q <= 1'b0;
				late_q <= 1'b0;
			end
		end
	end

	// Snoop: take the other master's address one bus cycle after its start
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			snoopArm_q <= 1'b0;
			snoopValid_q <= 1'b0;
			snoopAddr_q <= '0;
		end else begin
			snoopValid_q <= 1'b0;
			if (busTick) begin
				snoopArm_q <= snoopStart;
				if (snoopArm_q) begin
					snoopAddr_q <= bus.addrBus;
					snoopValid_q <= 1'b1;
				end
			end
		end
	end

	assign bus.addrBusRequestN = reqN_q;
	assign bus.highPriorityRequestN = hprN_q;
	assign bus.dataBusRequestN = dbrN_q;
	assign bus.devAddrOe = oe_q;
	assign bus.devAddr = addr_q;
	assign bus.devAttr = attr_q;
	assign bus.devParity = parity_q;
	assign txnReady = ready_q;
	assign tenureDone = done_q;
	assign snoopValid = snoopValid_q;
	assign snoopAddr = snoopAddr_q;
endmodule : addr_bus_master

// ==== core/addr_bus_arbiter.sv ====
// Arbiter end: grants the master, drives the start line, and models one other master.
// Assumes the master end runs on the same processor clock and reset.
`timescale 1ns/1ps
`include "addr_bus_map.svh"

module addr_bus_arbiter #(
	parameter int BUS_RATIO = `ABM_BUS_RATIO
) (
	input wire logic clk_sys, // Processor clock, 250 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic grantEnable, // Allows grants to the master
	input wire logic startLate, // Start one bus cycle after grant
	input wire logic otherReq, // Other master wants an address tenure
	input wire addr_bus_pkg::addr_t otherAddr, // Its physical address
	output logic otherTaken, // Pulse: other request taken
	output logic devGranted, // Pulse: grant issued to the master
	addr_bus_if.arb_end bus // Bus lines
);
	import addr_bus_pkg::*;

	logic busTick;
	logic busPreTick;
	arb_state_t state_q;
	logic grantN_q;
	logic eatsN_q;
	logic othOe_q;
	addr_t othAddr_q;
	logic lastDev_q;
	logic otherTaken_q;
	logic devGranted_q;

	bus_clk_div #(.RATIO(BUS_RATIO)) bus_clk_div_inst (
		.clk_sys(clk_sys),
		.srst(srst),
		.busTick(busTick),
		.busPreTick()
	);

	// Grant only against a standing request, alternate under contention unless the master requests high priority
	wire logic devWants = !bus.addrBusRequestN && grantEnable;
	wire logic devFirst = !otherReq || !bus.highPriorityRequestN || !lastDev_q;
	wire logic idleTick = busTick && (state_q == A_IDLE);
	wire logic pickDev = idleTick && devWants && devFirst;
	wire logic pickOth = idleTick && otherReq && !pickDev;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= A_IDLE;
			grantN_q <= `ABM_NEGATED;
			eatsN_q <= `ABM_NEGATED;
			othOe_q <= 1'b0;
			othAddr_q <= '0;
			lastDev_q <= 1'b0;
			otherTaken_q <= 1'b0;
			devGranted_q <= 1'b0;
		end else begin
			otherTaken_q <= pickOth;
			devGranted_q <= pickDev;
			if (busTick) begin
				unique case (state_q)
					A_IDLE: begin
						othOe_q <= 1'b0;
						if (pickDev || pickOth) begin
							grantN_q <= !pickDev;
							eatsN_q <= startLate;
							lastDev_q <= pickDev;
							state_q <= A_GRANT;
						end
						if (pickOth) begin
							othAddr_q <= otherAddr;
						end
					end
					A_GRANT: begin
						grantN_q <= `ABM_NEGATED;
						othOe_q <= !lastDev_q;
						eatsN_q <= !eatsN_q;
						state_q <= eatsN_q ? A_START : A_IDLE;
					end
					A_START: begin
						eatsN_q <= `ABM_NEGATED;
						state_q <= A_IDLE;
					end
					default: begin
						state_q <= A_IDLE;
					end
				endcase
			end
		end
	end

	assign bus.addrBusGrantN = grantN_q;
	assign bus.earlyAddrStartN = eatsN_q;
	assign bus.othAddrOe = othOe_q;
	assign bus.othAddr = othAddr_q;
	assign otherTaken = otherTaken_q;
	assign devGranted = devGranted_q;
endmodule : addr_bus_arbiter

// ==== test/address_bus_request_and_tenure_asserts.sv ====
// Checker: properties on the arbitration and tenure lines.
// Assumes a bus ratio of 2 and one shared clock.
`timescale 1ns/1ps

module address_bus_request_and_tenure_asserts (
	input wire logic clk_sys, // Clock
	input wire logic srst, // Reset
	input wire logic busLookaheadEnable, // Lookahead
	input wire logic addrBusRequestN, // Request
	input wire logic addrBusGrantN, // Grant
	input wire logic highPriorityRequestN, // Priority
	input wire logic dataBusRequestN, // Data request
	input wire logic earlyAddrStartN, // Start
	input wire logic devAddrOe, // Drive enable
	input wire addr_bus_pkg::addr_t devAddr, // Address
	input wire addr_bus_pkg::attr_t devAttr, // Attributes
	input wire addr_bus_pkg::parity_t devParity // Parity
);
	import addr_bus_pkg::*;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence earlyStart;
		$fell(addrBusGrantN) && $fell(earlyAddrStartN);
	endsequence
	sequence lateStart;
		$fell(addrBusGrantN) && earlyAddrStartN ##2 $fell(earlyAddrStartN);
	endsequence

	a_grant_one_bus: assert property (
		$fell(addrBusGrantN) |=> !addrBusGrantN ##1 addrBusGrantN)
		else $error("grant pulse length wrong");
	a_grant_spacing: assert property (
		$fell(addrBusGrantN) |=> (!$fell(addrBusGrantN)) [*3])
		else $error("grants closer than every other bus cycle");
	a_start_one_bus: assert property (
		$fell(earlyAddrStartN) |=> !earlyAddrStartN ##1 earlyAddrStartN)
		else $error("start pulse length wrong");
	a_start_follows_grant: assert property (
		$fell(addrBusGrantN) |-> ##[0:2] $fell(earlyAddrStartN))
		else $error("start late after grant");
	a_grant_needs_req: assert property (
		$fell(addrBusGrantN) |-> !$past(addrBusRequestN))
		else $error("grant without request");
	a_req_drops_drive: assert property (
		$fell(addrBusGrantN) |-> ##2 addrBusRequestN && devAddrOe)
		else $error("request or drive wrong after grant");
	a_early_tenure: assert property (
		earlyStart |-> ##2 devAddrOe [*2] ##1 !devAddrOe)
		else $error("early tenure length wrong");
	a_late_tenure: assert property (
		lateStart |-> devAddrOe [*3] ##1 (devAddrOe != busLookaheadEnable) ##1 !devAddrOe)
		else $error("late tenure length wrong");
	a_drive_after_grant: assert property (
		$rose(devAddrOe) |-> !$past(addrBusGrantN))
		else $error("drive without grant");
	a_parity_odd: assert property (
		devAddrOe |-> ^{devAddr[63:32], devParity[0]} && ^{devAddr[31:0], devParity[1]}
			&& ^{devAttr, devParity[2]})
		else $error("address parity not odd");
	a_priority_needs_req: assert property (
		!highPriorityRequestN |-> !dataBusRequestN || !$past(addrBusRequestN)
			|| !$past(addrBusRequestN, 2))
		else $error("priority without request");
endmodule : address_bus_request_and_tenure_asserts

// ==== test/address_bus_request_and_tenure_tb_top.sv ====
// Bench: master and arbiter ends joined by the bus interface.
// Assumes the core files are compiled first.
`timescale 1ns/1ps

module address_bus_request_and_tenure_tb_top;
	import addr_bus_pkg::*;

	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic lookahead = 1'b0;
	logic txnValid = 1'b0;
	logic txnHighPri = 1'b0;
	logic queuedHighPri = 1'b0;
	logic dataReq = 1'b0;
	logic dataHighPri = 1'b0;
	logic grantEnable = 1'b0;
	logic startLate = 1'b0;
	logic otherReq = 1'b0;
	addr_t txnAddr = '0;
	addr_t otherAddr = '0;
	attr_t txnAttr = '0;
	logic txnReady, tenureDone, snoopValid, otherTaken, devGranted;
	addr_t snoopAddr;
	int nErrors = 0;
	int testsRun = 0;

	always #2 clk_sys = ~clk_sys;

	addr_bus_if addr_bus_if_inst ();
	addr_bus_master addr_bus_master_inst (.clk_sys(clk_sys), .srst(srst),
		.busLookaheadEnable(lookahead), .txnValid(txnValid), .txnAddr(txnAddr),
		.txnAttr(txnAttr), .txnHighPri(txnHighPri), .queuedHighPri(queuedHighPri),
		.dataReq(dataReq), .dataHighPri(dataHighPri), .txnReady(txnReady),
		.tenureDone(tenureDone), .snoopValid(snoopValid), .snoopAddr(snoopAddr),
		.bus(addr_bus_if_inst));
	addr_bus_arbiter addr_bus_arbiter_inst (.clk_sys(clk_sys), .srst(srst),
		.grantEnable(grantEnable), .startLate(startLate), .otherReq(otherReq),
		.otherAddr(otherAddr), .otherTaken(otherTaken), .devGranted(devGranted),
		.bus(addr_bus_if_inst));
	address_bus_request_and_tenure_asserts address_bus_request_and_tenure_asserts_inst (
		.clk_sys(clk_sys), .srst(srst), .busLookaheadEnable(lookahead),
		.addrBusRequestN(addr_bus_if_inst.addrBusRequestN),
		.addrBusGrantN(addr_bus_if_inst.addrBusGrantN),
		.highPriorityRequestN(addr_bus_if_inst.highPriorityRequestN),
		.dataBusRequestN(addr_bus_if_inst.dataBusRequestN),
		.earlyAddrStartN(addr_bus_if_inst.earlyAddrStartN),
		.devAddrOe(addr_bus_if_inst.devAddrOe), .devAddr(addr_bus_if_inst.devAddr),
		.devAttr(addr_bus_if_inst.devAttr), .devParity(addr_bus_if_inst.devParity));

	task automatic wrapUp;
		$display("Counts: checks %0d mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrapUp

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		testsRun++;
		if (got !== exp) begin
			nErrors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic waitHigh(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1) begin
			@(negedge clk_sys);
			n++;
			if (n > 60) begin
				check(64'h0, 64'h1);
				wrapUp();
			end
		end
	endtask : waitHigh

	function automatic int expOe(input logic late, input logic la);
		return late ? (la ? 3 : 4) : 2;
	endfunction : expOe

	// One own tenure; counts drive cycles and captures the bus
	task automatic runTxn(input logic late, input logic la, input addr_t a, input attr_t t);
		int oeCnt;
		int nGrant;
		int n;
		logic sawReq;
		addr_t seen;
		attr_t seenAttr;
		oeCnt = 0;
		nGrant = 0;
		n = 0;
		sawReq = 1'b0;
		seen = '0;
		seenAttr = '0;
		startLate = late;
		lookahead = la;
		txnAddr = a;
		txnAttr = t;
		txnValid = 1'b1;
		@(negedge clk_sys);
		while (txnReady !== 1'b0 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		txnValid = 1'b0;
		while (tenureDone !== 1'b1 && n < 60) begin
			@(negedge clk_sys);
			n++;
			if (addr_bus_if_inst.addrBusRequestN === 1'b0) sawReq = 1'b1;
			if (devGranted === 1'b1) nGrant++;
			if (addr_bus_if_inst.devAddrOe === 1'b1) begin
				oeCnt++;
				seen = addr_bus_if_inst.addrBus;
				seenAttr = addr_bus_if_inst.attrBus;
			end
		end
		if (n >= 60) begin
			check(64'h0, 64'h1);
			wrapUp();
		end
		check(sawReq, 1);
		check(nGrant, 1);
		check(oeCnt, expOe(late, la));
		check(seen, a);
		check(seenAttr, t);
		@(negedge clk_sys);
	endtask : runTxn

	initial begin
		void'($urandom(99));
		repeat (16) @(negedge clk_sys);
		srst = 1'b0;
		grantEnable = 1'b1;
		for (int i = 0; i < 4; i++) runTxn(i[0], i[1], {i[1], 62'h0, 1'b1}, 10'h3FF);
		for (int i = 0; i < 20; i++) begin
			runTxn($urandom % 2, $urandom % 2, {$urandom, $urandom}, attr_t'($urandom));
		end
		$display("Test tenures done");
		for (int j = 0; j < 3; j++) begin
			grantEnable = 1'b0;
			txnHighPri = (j == 0);
			queuedHighPri = (j == 1);
			txnValid = (j != 2);
			dataReq = (j == 2);
			dataHighPri = (j == 2);
			repeat (12) @(negedge clk_sys);
			txnValid = 1'b0;
			check(addr_bus_if_inst.addrBusRequestN, j == 2);
			check(addr_bus_if_inst.devAddrOe, 0);
			check(addr_bus_if_inst.highPriorityRequestN, 0);
			check(addr_bus_if_inst.dataBusRequestN, j != 2);
			txnHighPri = 1'b0;
			queuedHighPri = 1'b0;
			dataReq = 1'b0;
			dataHighPri = 1'b0;
			grantEnable = 1'b1;
			if (j != 2) waitHigh(tenureDone);
			repeat (6) @(negedge clk_sys);
			check(addr_bus_if_inst.highPriorityRequestN, 1);
		end
		$display("Test priority done");
		for (int i = 0; i < 6; i++) begin
			startLate = i[0];
			otherAddr = {$urandom, $urandom};
			otherReq = 1'b1;
			waitHigh(otherTaken);
			otherReq = 1'b0;
			waitHigh(snoopValid);
			check(snoopAddr, otherAddr);
			@(negedge clk_sys);
		end
		$display("Test snoop done");
		wrapUp();
	end
endmodule : address_bus_request_and_tenure_tb_top
